/* File: src/sram_host_defines.svh */
// Purpose: timing and geometry constants for the async SRAM host controller
// Assumes: 100 MHz sys_clk (10 ns period)
// Notes: cycle counts derive from ns figures; least times round up
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define ADDR_WIDTH 13
`define DATA_WIDTH 8
`define MEM_DEPTH 8192
// Least times in ns
`define ADDRESS_ACCESS_TIME_NS 25
`define WRITE_TO_FLOAT_DELAY_NS 12
`define DESELECT_TO_FLOAT_DELAY_NS 12
`define ADDRESS_SETUP_TO_WRITE_END_NS 20
`define WRITE_DATA_SETUP_NS 12
`define DESELECT_TO_POWERDOWN_DELAY_NS 20
// Cycle counts, rounded up, at least one
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC `CEIL_CYC(`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS)
`define FLOAT_WAIT_CYC `CEIL_CYC(`WRITE_TO_FLOAT_DELAY_NS)
`define WRITE_PULSE_CYC `CEIL_CYC(`ADDRESS_SETUP_TO_WRITE_END_NS)
`define RECOVER_CYC `CEIL_CYC(`DESELECT_TO_FLOAT_DELAY_NS)
`define CNT_WIDTH 4

`endif

/* File: src/sram_host_pkg.sv */
// Purpose: types for the async SRAM host controller
// Assumes: constants come from sram_host_defines.svh
// Notes: none
`include "sram_host_defines.svh"
package sram_host_pkg;
	typedef struct packed {
		logic write;
		logic [`ADDR_WIDTH-1:0] addr;
		logic [`DATA_WIDTH-1:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic select_active_low;
		logic select_active_high;
		logic output_enable_n;
		logic write_enable_n;
		logic [`ADDR_WIDTH-1:0] addr;
	} sram_ctrl_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_READ = 5'h02,
		ST_WR_SETUP = 5'h04,
		ST_WR_PULSE = 5'h08,
		ST_RECOVER = 5'h10
	} host_state_t;
endpackage

/* File: src/sram_host.sv */
// Purpose: host controller driving an 8k x 8 asynchronous static memory
// Assumes: memory pins are sampled synchronous to sys_clk
// Notes: one access at a time; req_ready high only in idle
//   the memory is deselected between accesses so it can power down
//   read data is sampled as a synchronous input, with no resync stage
//   a write is ended by the strobe and both selects on one edge
// Functional notes
// - Write strobe high means read, low means write; it stays high through reads.
// - All write qualifiers must be valid to start a write; the first to drop ends it.
// - Write data is stable for the setup time before and the hold time after write end.
// - Address is stable for the setup time before and the hold time after write end.
// - For a select-timed read the address is valid before both enables go active; here address, selects and output enable change on one edge.
`timescale 1ns/1ps
`include "sram_host_defines.svh"

module sram_host
	import sram_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input sram_host_pkg::host_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [`DATA_WIDTH-1:0] rdata,
	output logic rdata_valid,
	output sram_host_pkg::sram_ctrl_t sram_ctrl,
	output logic [`DATA_WIDTH-1:0] data_bus_pins_out,
	output logic data_bus_pins_oe,
	input wire logic [`DATA_WIDTH-1:0] data_bus_pins_in
);
	import sram_host_pkg::*;

	// Phase lengths in clock cycles; each counts down to one
	localparam logic [`CNT_WIDTH-1:0] READ_WAIT = `CNT_WIDTH'(`READ_WAIT_CYC);
	localparam logic [`CNT_WIDTH-1:0] FLOAT_WAIT = `CNT_WIDTH'(`FLOAT_WAIT_CYC);
	localparam logic [`CNT_WIDTH-1:0] WRITE_PULSE = `CNT_WIDTH'(`WRITE_PULSE_CYC);
	localparam logic [`CNT_WIDTH-1:0] RECOVER = `CNT_WIDTH'(`RECOVER_CYC);

	host_state_t state_reg;
	logic [`CNT_WIDTH-1:0] count_reg;
	logic [`ADDR_WIDTH-1:0] addr_reg;
	logic [`DATA_WIDTH-1:0] wdata_reg;
	logic count_done;
	logic take_req;
	logic read_phase;
	logic write_phase;
	logic access_phase;
	logic data_hold;

	assign count_done = (count_reg == `CNT_WIDTH'h1);

	// ==========================================================
	// Phase decode
	always_comb begin
		take_req = (state_reg == ST_IDLE) && req_valid;
		read_phase = (state_reg == ST_READ);
		write_phase = (state_reg == ST_WR_SETUP) || (state_reg == ST_WR_PULSE);
		access_phase = read_phase || write_phase;
		// One extra driven cycle after the strobe edge gives the data hold
		data_hold = (state_reg == ST_RECOVER) && (count_reg == RECOVER) && data_bus_pins_oe;
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			count_reg <= `CNT_WIDTH'h0;
		end else begin
			unique case (state_reg)
				// Requests are looked at only here; others wait
				ST_IDLE: begin
					if (req_valid) begin
						if (req.write) begin
							state_reg <= ST_WR_SETUP;
							count_reg <= FLOAT_WAIT;
						end else begin
							state_reg <= ST_READ;
							count_reg <= READ_WAIT;
						end
					end
				end
				// Selected with outputs on for the access time
				ST_READ: begin
					if (count_done) begin
						state_reg <= ST_RECOVER;
						count_reg <= RECOVER;
					end else begin
						count_reg <= count_reg - `CNT_WIDTH'h1;
					end
				end
				// Selected, strobe low, our drivers off until memory floats
				ST_WR_SETUP: begin
					if (count_done) begin
						state_reg <= ST_WR_PULSE;
						count_reg <= WRITE_PULSE;
					end else begin
						count_reg <= count_reg - `CNT_WIDTH'h1;
					end
				end
				// Data driven, strobe still low
				ST_WR_PULSE: begin
					if (count_done) begin
						state_reg <= ST_RECOVER;
						count_reg <= RECOVER;
					end else begin
						count_reg <= count_reg - `CNT_WIDTH'h1;
					end
				end
				// Deselected; lets the memory float before next access
				ST_RECOVER: begin
					if (count_done) begin
						state_reg <= ST_IDLE;
					end else begin
						count_reg <= count_reg - `CNT_WIDTH'h1;
					end
				end
				// Stray code: fall back to a safe idle
				default: begin
					state_reg <= ST_IDLE;
					count_reg <= `CNT_WIDTH'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Address latch, taken with the request
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			addr_reg <= `ADDR_WIDTH'h0;
		end else if (take_req) begin
			addr_reg <= req.addr;
		end
	end

	// ==========================================================
	// Write data latch
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wdata_reg <= `DATA_WIDTH'h0;
		end else if (take_req) begin
			// Latched for reads too; the driver stays off then
			wdata_reg <= req.wdata;
		end
	end

	// ==========================================================
	// Memory pins, all registered
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sram_ctrl.select_active_low <= 1'b1;
			sram_ctrl.select_active_high <= 1'b0;
			sram_ctrl.output_enable_n <= 1'b1;
			sram_ctrl.write_enable_n <= 1'b1;
			sram_ctrl.addr <= `ADDR_WIDTH'h0;
		end else begin
			// Address moves on the same edge as select, held through recovery
			sram_ctrl.addr <= addr_reg;
			// Deselect between accesses to let the memory power down
			sram_ctrl.select_active_low <= !access_phase;
			sram_ctrl.select_active_high <= access_phase;
			sram_ctrl.output_enable_n <= !read_phase;
			// Strobe ends the write together with deselect, one common edge
			sram_ctrl.write_enable_n <= !write_phase;
		end
	end

	// ==========================================================
	// Write data driver
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_bus_pins_out <= `DATA_WIDTH'h0;
			data_bus_pins_oe <= 1'b0;
		end else begin
			// Drive only after the float delay; held one cycle past write end
			data_bus_pins_oe <= (state_reg == ST_WR_PULSE) || data_hold;
			data_bus_pins_out <= wdata_reg;
		end
	end

	// ==========================================================
	// Read capture
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rdata <= `DATA_WIDTH'h0;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= read_phase && count_done;
			if (read_phase && count_done) begin
				rdata <= data_bus_pins_in;
			end
		end
	end

	// ==========================================================
	// Request handshake
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			req_ready <= 1'b0;
		end else begin
			// Drops at once when a request is taken in idle
			req_ready <= ((state_reg == ST_IDLE) && !req_valid) ||
				((state_reg == ST_RECOVER) && count_done);
		end
	end
endmodule // sram_host

/* File: verif/sram_host_sva.sv */
// Purpose: pin timing checks for sram_host
// Assumes: 10 ns clock
// Notes: bound below
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module sram_host_sva
	import sram_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input sram_host_pkg::sram_ctrl_t sram_ctrl,
	input wire logic [`DATA_WIDTH-1:0] data_bus_pins_out,
	input wire logic data_bus_pins_oe
);
	import sram_host_pkg::*;
	logic sel;
	logic wov;
	assign sel = !sram_ctrl.select_active_low && sram_ctrl.select_active_high;
	assign wov = sel && !sram_ctrl.write_enable_n;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// Write overlap steps
	sequence s_pulse;
		wov [*3];
	endsequence
	// Host stays off the bus while the memory floats
	sequence s_float;
		!data_bus_pins_oe ##1 !data_bus_pins_oe;
	endsequence
	chk_read_strobe_high:
	assert property (!sram_ctrl.output_enable_n |-> sram_ctrl.write_enable_n) else $error("oe with we");
	chk_write_pulse_len:
	assert property ($rose(wov) |-> s_pulse) else $error("short write");
	chk_data_window:
	assert property ($fell(wov) |-> $past(data_bus_pins_oe, 2) && data_bus_pins_oe
		&& $stable(data_bus_pins_out)) else $error("data window");
	chk_addr_steady:
	assert property (sel && $past(sel) |-> $stable(sram_ctrl.addr)) else $error("addr moved");
	chk_select_addr:
	assert property ($rose(sel) |=> $stable(sram_ctrl.addr)) else $error("addr late");
	chk_float_wait:
	assert property ($fell(sram_ctrl.write_enable_n) |-> s_float) else $error("drive before float");
endmodule // sram_host_sva
bind sram_host sram_host_sva sram_host_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b),
	.sram_ctrl(sram_ctrl), .data_bus_pins_out(data_bus_pins_out),
	.data_bus_pins_oe(data_bus_pins_oe));

/* File: verif/sram_model.sv */
// Purpose: 8k x 8 memory model
// Assumes: pins sampled on sys_clk
// Notes: floated bus shows inverted last level
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module sram_model
	import sram_host_pkg::*;
(
	input wire logic sys_clk,
	input sram_host_pkg::sram_ctrl_t ctrl,
	input wire logic [7:0] host_out,
	input wire logic host_oe,
	output logic [7:0] bus
);
	logic [7:0] mem [0:`MEM_DEPTH-1];
	logic sel;
	logic wov;
	logic wr_reg;
	logic rd_reg;
	logic [12:0] wa_reg;
	logic [7:0] wd_reg;
	logic [7:0] last_reg;
	assign sel = !ctrl.select_active_low && ctrl.select_active_high;
	assign wov = sel && !ctrl.write_enable_n;
	always_ff @(posedge sys_clk) begin
		wr_reg <= wov;
		wa_reg <= ctrl.addr;
		wd_reg <= bus;
		rd_reg <= sel && !ctrl.output_enable_n && ctrl.write_enable_n;
		last_reg <= bus;
		if (wr_reg && !wov) mem[wa_reg] <= wd_reg;
	end
	// Drive from one cycle into a read until the read ends, float otherwise
	always_comb begin
		if (host_oe) bus = host_out;
		else if (rd_reg && sel && !ctrl.output_enable_n && ctrl.write_enable_n) bus = mem[ctrl.addr];
		else bus = ~last_reg;
	end
endmodule // sram_model

/* File: verif/testbench.sv */
// Purpose: self-checking bench for sram_host
// Assumes: sram_model on memory pins
// Notes: fixed stimulus
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module testbench;
	import sram_host_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	host_req_t req = '0;
	logic req_valid = 1'b0;
	logic req_ready;
	logic [7:0] rdata;
	logic rdata_valid;
	sram_ctrl_t ctl;
	logic [7:0] bo;
	logic oe;
	logic [7:0] bus;
	logic [7:0] q;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [12:0] adr [5] = '{13'h0000, 13'h0001, 13'h0aaa, 13'h1555, 13'h1fff};
	sram_host sram_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .sram_ctrl(ctl),
		.data_bus_pins_out(bo), .data_bus_pins_oe(oe), .data_bus_pins_in(bus));
	sram_model sram_model_inst (.sys_clk(sys_clk), .ctrl(ctl), .host_out(bo), .host_oe(oe),
		.bus(bus));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req <= '{w, a, d};
		req_valid <= 1'b1;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		n = 0;
		if (!w) begin
			do begin
				@(posedge sys_clk);
				n++;
			end while (rdata_valid !== 1'b1);
			q = rdata;
			check("read latency", 8'(`READ_WAIT_CYC + 1), 8'(n));
			@(posedge sys_clk);
			check("valid pulse", 8'h00, {7'h00, rdata_valid});
		end
	endtask
	task automatic test_reset();
		repeat (20) @(posedge sys_clk);
		check("idle pins", 8'h2c, {2'b00, ctl[16:13], oe, req_ready});
		rst_b <= 1'b1;
		$display("reset done");
	endtask
	task automatic test_edges();
		foreach (adr[i]) xfer(1'b1, adr[i], adr[i][7:0] ^ 8'h5a);
		foreach (adr[i]) begin
			xfer(1'b0, adr[i], 8'h00);
			check("read", adr[i][7:0] ^ 8'h5a, q);
		end
		$display("edges done");
	endtask
	task automatic test_overwrite();
		xfer(1'b1, 13'h0aab, 8'h00);
		xfer(1'b1, 13'h0aab, 8'hff);
		xfer(1'b0, 13'h0aab, 8'h00);
		check("rewrite", 8'hff, q);
		xfer(1'b0, 13'h0aaa, 8'h00);
		check("neighbour", 8'hf0, q);
		$display("overwrite done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		test_reset();
		test_edges();
		test_overwrite();
		finish_test();
	end
endmodule // testbench
